// ==== hdl/byte_swap_pkg.sv ====
// shared constants and carrier types for the host byte order steering
package byte_swap_pkg;
  // ---------------------------------------------------------------
  // halfword swap key, buffer sizing and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] SWAP_KEY = 32'hFFFF_FFFF;
  localparam int WORD_FIFO_DEPTH = 16;
  localparam logic [15:0] RD_DATA_RESET = 16'h0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // access kinds and half collection states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CSR = 2'b00,
    KIND_PORT = 2'b01,
    KIND_SEL = 2'b10,
    KIND_STATUS = 2'b11
  } access_kind_e;

  typedef enum logic [1:0] {
    HALF_NONE = 2'b00,
    HALF_UPPER = 2'b01,
    HALF_LOWER = 2'b10
  } half_state_e;

  // one host halfword access
  typedef struct packed {
    access_kind_e kind;
    logic halfword_address_bit;
    logic [15:0] data;
  } host_req_s;

  // one assembled internal word
  typedef struct packed {
    access_kind_e kind;
    logic [31:0] data;
  } word_s;
endpackage

// ==== hdl/host_byte_order_swap.sv ====
// host byte order steering between a 16-bit host bus and 32-bit words
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// generic flip-flop word buffer
// ---------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];
  localparam logic [AW-1:0] LAST_INDEX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0] count_r, count_nxt;
  logic push, pop;

  // handshakes straight from the occupancy count
  assign in_ready_out = (count_r != FULL_COUNT);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // pointer wrap works for any depth, not only powers of two
  always_comb begin
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data_in;
      wr_ptr_nxt = (wr_ptr_r == LAST_INDEX) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST_INDEX) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end
endmodule

module host_byte_order_swap #(
  parameter int FIFO_DEPTH = byte_swap_pkg::WORD_FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [31:0] word_swap_in,
  input wire logic data_port_big_endian_in,
  input wire logic direct_select_big_endian_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire byte_swap_pkg::host_req_s host_req_in,
  output logic host_wr_ready_out,
  output logic [15:0] host_rd_data_out,
  input wire logic [31:0] rd_word_in,
  output logic rd_word_pop_out,
  output byte_swap_pkg::word_s word_out,
  output logic word_valid_out,
  input wire logic word_ready_in
);
  import byte_swap_pkg::*;

  // ---------------------------------------------------------------
  // lane steering helpers
  // ---------------------------------------------------------------
  // picks the internal half that the host lanes meet
  function automatic logic lane_upper(input logic swap, input logic big,
                                      input logic addr_bit);
    lane_upper = (addr_bit ^ swap) ^ big;
  endfunction

  // bytes within a half, optionally reversed
  function automatic logic [15:0] lane_order(input logic [15:0] half,
                                             input logic big);
    lane_order = big ? {half[7:0], half[15:8]} : half;
  endfunction

  // endian bit chosen by access kind
  // direct select bit alone for direct accesses
  function automatic logic kind_big(input access_kind_e kind,
                                    input logic port_be, input logic sel_be);
    case (kind)
      KIND_PORT: kind_big = port_be;
      KIND_SEL: kind_big = sel_be;
      default: kind_big = 1'b0;
    endcase
  endfunction

  logic swap_on;
  logic req_big;
  logic req_upper;
  logic [15:0] req_lanes;

  // exact key match, anything else means no swap
  assign swap_on = (word_swap_in == SWAP_KEY);
  // same decode serves every access kind
  assign req_big = kind_big(host_req_in.kind, data_port_big_endian_in,
                            direct_select_big_endian_in);
  assign req_upper = lane_upper(swap_on, req_big,
                                host_req_in.halfword_address_bit);
  assign req_lanes = lane_order(host_req_in.data, req_big);

  // ---------------------------------------------------------------
  // write path: halves collect into one word, then the buffer
  // ---------------------------------------------------------------
  half_state_e wr_state_r, wr_state_nxt;
  logic [15:0] wr_hold_r, wr_hold_nxt;
  logic wr_completes;
  logic wr_take;
  word_s wr_word;
  logic fifo_in_ready;

  // second access to the other half closes the word
  assign wr_completes = host_wr_in &&
    ((wr_state_r == HALF_UPPER && !req_upper) ||
     (wr_state_r == HALF_LOWER && req_upper));
  // stall only the closing access while the buffer is full
  assign host_wr_ready_out = !wr_completes || fifo_in_ready;
  assign wr_take = host_wr_in && host_wr_ready_out;
  assign wr_word.kind = host_req_in.kind;
  assign wr_word.data = req_upper ? {req_lanes, wr_hold_r}
                                  : {wr_hold_r, req_lanes};

  // a repeated half throws away the partial word and itself; the next access starts over
  always_comb begin
    wr_state_nxt = wr_state_r;
    wr_hold_nxt = wr_hold_r;
    if (wr_take) begin
      case (wr_state_r)
        HALF_NONE: begin
          wr_state_nxt = req_upper ? HALF_UPPER : HALF_LOWER;
          wr_hold_nxt = req_lanes;
        end
        HALF_UPPER, HALF_LOWER: begin
          if (wr_completes) begin
            wr_state_nxt = HALF_NONE;
          end else begin
            wr_state_nxt = HALF_NONE;
          end
        end
        default: wr_state_nxt = HALF_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_state_r <= HALF_NONE;
      wr_hold_r <= RD_DATA_RESET;
    end else begin
      wr_state_r <= wr_state_nxt;
      wr_hold_r <= wr_hold_nxt;
    end
  end

  // buffer decouples the host from a slow word consumer
  word_fifo #(
    .WIDTH($bits(word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_word_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(wr_completes),
    .in_ready_out(fifo_in_ready),
    .in_data_in(wr_word),
    .out_valid_out(word_valid_out),
    .out_ready_in(word_ready_in),
    .out_data_out(word_out)
  );

  // ---------------------------------------------------------------
  // read path: steer the current word, count halves for the pop
  // ---------------------------------------------------------------
  half_state_e rd_state_r, rd_state_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic rd_pop_r, rd_pop_nxt;
  logic [15:0] rd_half;

  assign rd_half = lane_order(req_upper ? rd_word_in[31:16]
                                        : rd_word_in[15:0], req_big);
  assign host_rd_data_out = rd_data_r;
  assign rd_word_pop_out = rd_pop_r;

  // a repeated half resets the count; that read is invalid, not fatal
  always_comb begin
    rd_state_nxt = rd_state_r;
    rd_data_nxt = rd_data_r;
    rd_pop_nxt = 1'b0;
    if (host_rd_in) begin
      rd_data_nxt = rd_half;
      case (rd_state_r)
        HALF_NONE: begin
          rd_state_nxt = req_upper ? HALF_UPPER : HALF_LOWER;
        end
        HALF_UPPER: begin
          rd_state_nxt = HALF_NONE;
          rd_pop_nxt = !req_upper;
        end
        HALF_LOWER: begin
          rd_state_nxt = HALF_NONE;
          rd_pop_nxt = req_upper;
        end
        default: rd_state_nxt = HALF_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_state_r <= HALF_NONE;
      rd_data_r <= RD_DATA_RESET;
      rd_pop_r <= 1'b0;
    end else begin
      rd_state_r <= rd_state_nxt;
      rd_data_r <= rd_data_nxt;
      rd_pop_r <= rd_pop_nxt;
    end
  end
endmodule

`default_nettype wire

// ==== verif/swap_props.sv ====
// assertions on the host byte steering ports
`timescale 1ns/10ps
`default_nettype none
module swap_props import byte_swap_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [31:0] word_swap_in,
  input wire logic data_port_big_endian_in,
  input wire logic direct_select_big_endian_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire host_req_s host_req_in,
  input wire logic host_wr_ready_out,
  input wire logic [15:0] host_rd_data_out,
  input wire logic [31:0] rd_word_in,
  input wire logic rd_word_pop_out,
  input wire logic word_valid_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic sw, a, r;
  access_kind_e k;
  logic [31:0] w;
  // read strobe qualified by no swap
  assign sw = word_swap_in == SWAP_KEY;
  assign a = host_req_in.halfword_address_bit;
  assign k = host_req_in.kind;
  assign w = rd_word_in;
  assign r = host_rd_in && !sw;
  csr_hi_a: assert property (
    r && a && k == KIND_CSR
    |=> host_rd_data_out == $past(w[31:16])) else $error("csr hi");
  csr_lo_a: assert property (
    r && !a && k == KIND_CSR
    |=> host_rd_data_out == $past(w[15:0])) else $error("csr lo");
  swap_inv_a: assert property (
    host_rd_in && sw && a && k == KIND_CSR
    |=> host_rd_data_out == $past(w[15:0])) else $error("swap");
  port_be_a: assert property (
    r && a && k == KIND_PORT && data_port_big_endian_in
    |=> host_rd_data_out == {$past(w[7:0]), $past(w[15:8])})
    else $error("port be");
  sel_be_a: assert property (
    r && !a && k == KIND_SEL && direct_select_big_endian_in
    |=> host_rd_data_out == {$past(w[23:16]), $past(w[31:24])})
    else $error("sel be");
  status_fix_a: assert property (
    r && a && k == KIND_STATUS
    |=> host_rd_data_out == $past(w[31:16])) else $error("status");
  pop_cause_a: assert property (
    rd_word_pop_out |-> $past(host_rd_in)) else $error("pop");
  refuse_full_a: assert property (
    !host_wr_ready_out |-> host_wr_in && word_valid_out)
    else $error("ready low");
endmodule
bind host_byte_order_swap swap_props chk_u (.*);
`default_nettype wire

// ==== verif/host_cpu_model.sv ====
// host cpu model issuing halfword accesses
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model import byte_swap_pkg::*; (
  input wire logic clk_in,
  input wire logic wr_ready_in,
  input wire logic [15:0] rd_data_in,
  output logic wr_out,
  output logic rd_out,
  output host_req_s req_out,
  output logic [31:0] word_out
);
  initial begin
    wr_out = 0;
    rd_out = 0;
    req_out = '0;
    word_out = '0;
  end
  // raise a write just after the falling edge
  task put(input access_kind_e k, input logic a, input logic [15:0] d);
    @(negedge clk_in);
    wr_out = 1;
    req_out = '{k, a, d};
  endtask
  task fin;
    #1;
    while (!wr_ready_in) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    wr_out = 0;
    req_out.data = ~req_out.data; // released lines never keep old data
  endtask
  task rd_half(input access_kind_e k, input logic a, input logic [31:0] w,
      output logic [15:0] d);
    @(negedge clk_in);
    rd_out = 1;
    req_out = '{k, a, 16'h0000};
    word_out = w;
    @(negedge clk_in);
    d = rd_data_in;
    rd_out = 0;
    word_out = ~w;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the host byte order steering
`timescale 1ns/10ps
`default_nettype none
module tb;
  import byte_swap_pkg::*;
  logic sys_clk_in = 0, rstn_in = 0, word_ready_in = 0, hold = 1;
  logic data_port_big_endian_in = 0, direct_select_big_endian_in = 0;
  logic [31:0] word_swap_in = 0, rd_word_in;
  logic host_wr_in, host_rd_in, host_wr_ready_out, rd_word_pop_out;
  logic word_valid_out;
  logic [15:0] host_rd_data_out, d;
  host_req_s host_req_in;
  word_s word_out;
  word_s exp_q[$];
  access_kind_e k;
  logic [31:0] w;
  int miscompares = 0, comparisons = 0, seed = 10979, cyc = 0;
  host_byte_order_swap dut_u (.*);
  host_cpu_model p_u (.clk_in(sys_clk_in), .wr_ready_in(host_wr_ready_out),
    .rd_data_in(host_rd_data_out), .wr_out(host_wr_in), .rd_out(host_rd_in),
    .req_out(host_req_in), .word_out(rd_word_in));
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // expected lanes for one half of a word
  function logic [15:0] lane(input logic [31:0] v, input logic a);
    logic b;
    logic [15:0] h;
    b = k == KIND_PORT ? data_port_big_endian_in :
        k == KIND_SEL ? direct_select_big_endian_in : 1'b0;
    h = (a ^ b ^ (word_swap_in == SWAP_KEY)) ? v[31:16] : v[15:0];
    return b ? {h[7:0], h[15:8]} : h;
  endfunction
  task chk(input string n, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // consumer stalls at random so the buffer fills and drains
  always @(negedge sys_clk_in) word_ready_in <= !hold && $random(seed) % 2;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      tally_and_finish();
    end
    if (rstn_in && word_valid_out && word_ready_in)
      chk("word", exp_q.pop_front(), word_out);
  end
  task wword(input logic a);
    p_u.put(k, a, lane(w, a));
    p_u.fin();
    p_u.put(k, !a, lane(w, !a));
    p_u.fin();
    exp_q.push_back('{k, w});
  endtask
  task rword(input logic a);
    p_u.rd_half(k, a, w, d);
    chk("rd first", 34'(lane(w, a)), 34'(d));
    chk("no pop", 0, 34'(rd_word_pop_out));
    p_u.rd_half(k, !a, w, d);
    chk("rd second", 34'(lane(w, !a)), 34'(d));
    chk("pop", 1, 34'(rd_word_pop_out));
  endtask
  task drain;
    repeat (200) begin
      @(negedge sys_clk_in);
      if (!word_valid_out) break;
    end
    chk("drained", 0, 34'(word_valid_out + exp_q.size()));
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rstn_in = 1;
    hold = 0;
    // every kind under swap, near-key and random swap words
    for (int i = 0; i < 300; i++) begin
      word_swap_in = i[0] ? SWAP_KEY : i[1] ? 32'hFFFF_FFFE : $random(seed);
      {data_port_big_endian_in, direct_select_big_endian_in} = 2'(i >> 2);
      k = access_kind_e'(i >> 4);
      w = $random(seed);
      wword($random(seed) % 2);
      rword($random(seed) % 2);
    end
    drain();
    $display("test random mix done");
    // repeated half is dropped, read repeat gives no pop
    p_u.put(k, 1, 16'hA5A5);
    p_u.fin();
    p_u.put(k, 1, 16'h5A5A);
    p_u.fin();
    wword(0);
    p_u.rd_half(k, 1, w, d);
    p_u.rd_half(k, 1, w, d);
    chk("repeat pop", 0, 34'(rd_word_pop_out));
    drain();
    $display("test repeated half done");
    // sixteen words fill the buffer, closing half then refused
    hold = 1;
    repeat (16) wword(1);
    p_u.put(k, 0, lane(w, 0));
    p_u.fin();
    p_u.put(k, 1, lane(w, 1));
    #1 chk("wr ready", 0, 34'(host_wr_ready_out));
    hold = 0;
    p_u.fin();
    exp_q.push_back('{k, w});
    drain();
    $display("test full buffer done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
